// ### verilog/sre_pkg.sv
// Purpose: Shared constants and types of the serial EEPROM read engine.
// Assumes: Byte-wide two-wire link with 16-bit word addresses.
// Notes:   Every field position and code used by the engine lives here, except the sequencer state codes.
`default_nettype none
package sre_pkg;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned CS_W         = 3;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  // Device address byte layout.
  localparam int unsigned TYPE_MSB     = 7;
  localparam int unsigned TYPE_LSB     = 4;
  localparam int unsigned CS_MSB       = 3;
  localparam int unsigned CS_LSB       = 1;
  localparam int unsigned RW_BIT       = 0;
  localparam logic [3:0]  TYPE_MAIN    = 4'hA;
  localparam logic [3:0]  TYPE_SPECIAL = 4'hB;
  // Word address layout for the special areas (bit positions within the high byte).
  localparam int unsigned REGION_MSB   = 3;
  localparam int unsigned REGION_LSB   = 1;
  localparam logic [2:0]  REGION_IDENT = 3'h0;
  localparam logic [2:0]  REGION_SERIAL = 3'h1;
  localparam logic [2:0]  REGION_LOCK  = 3'h2;
  localparam int unsigned IDENT_IDX_W  = 7;
  localparam int unsigned SERIAL_IDX_W = 4;
  localparam int unsigned SERIAL_W     = 128;
  localparam int unsigned SYNC_STAGES  = 2;

  typedef enum logic [2:0] {
    AREA_MAIN,
    AREA_IDENT,
    AREA_SERIAL,
    AREA_LOCK,
    AREA_NONE
  } sre_area_e;

  typedef enum logic [1:0] {
    PH_DEV,
    PH_ADDR_HI,
    PH_ADDR_LO,
    PH_DATA
  } sre_phase_e;
endpackage : sre_pkg
`default_nettype wire

// ### verilog/sre_line_sync.sv
// Purpose: Synchronise the serial clock and data lines and find their events.
// Assumes: Both lines are asynchronous to i_mclk and much slower than it.
// Notes:   Start and stop are judged on the synchronised levels only.
`timescale 1ns/1ps
`default_nettype none
module sre_line_sync (
  input  wire logic i_mclk,      // System clock.
  input  wire logic i_rst,       // Asynchronous reset, active high.
  input  wire logic i_scl,       // Serial clock pin.
  input  wire logic i_sda,       // Serial data pin level.
  output logic      o_sda,       // Synchronised data level.
  output logic      o_scl_rise,  // Serial clock rising, one cycle.
  output logic      o_scl_fall,  // Serial clock falling, one cycle.
  output logic      o_start,     // Start or repeated start, one cycle.
  output logic      o_stop       // Stop condition, one cycle.
);
  // Bit 1 is the clock, bit 0 the data; both lines idle high.
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] prev_q;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      prev_q <= 2'h3;
    end else begin
      meta_q <= {i_scl, i_sda};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_sda      = sync_q[0];
  assign o_scl_rise = sync_q[1] & ~prev_q[1];
  assign o_scl_fall = ~sync_q[1] & prev_q[1];
  assign o_start    = sync_q[1] & prev_q[1] & prev_q[0] & ~sync_q[0];
  assign o_stop     = sync_q[1] & prev_q[1] & ~prev_q[0] & sync_q[0];
endmodule : sre_line_sync
`default_nettype wire

// ### verilog/sre_read_engine.sv
// Purpose: Read-side command engine of a two-wire serial EEPROM slave.
// Assumes: Main array and ident page sit in an outside memory read by address.
// Notes:   The serial block is a constant, so it cannot be altered by any path.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module sre_read_engine #(
  parameter logic [127:0] FACTORY_SERIAL = 128'h0123456789ABCDEFFEDCBA9876543210 // Arbitrary value.
) (
  input  wire logic        i_mclk,            // System clock, 250 MHz.
  input  wire logic        i_rst,             // Asynchronous reset, active high.
  input  wire logic        i_scl,             // Serial clock pin.
  input  wire logic        i_sda,             // Serial data pin level.
  output logic             o_sda_out,         // Serial data drive value.
  output logic             o_sda_oe,          // Serial data drive enable, high drives.
  input  wire logic        i_chip_select_bit2, // Strapped chip select bit 2.
  input  wire logic        i_chip_select_bit1, // Strapped chip select bit 1.
  input  wire logic        i_chip_select_bit0, // Strapped chip select bit 0.
  input  wire logic        i_prog_busy,       // Programming cycle running.
  input  wire logic        i_ident_locked,    // Ident page locked.
  output logic [15:0]      o_rd_addr,         // Read address to the memory.
  output logic             o_rd_ident,        // Read targets the ident page.
  input  wire logic [7:0]  i_rd_data          // Read data from the memory.
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_WAIT,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_TX_MORE
  } sre_state_e;

  sre_state_e               st_q;
  sre_pkg::sre_phase_e      ph_q;
  sre_pkg::sre_area_e       area_q;
  sre_pkg::sre_area_e       wr_area_q;
  sre_pkg::sre_area_e       wr_area_d;
  logic [2:0]               bit_cnt_q;
  logic [7:0]               shift_q;
  logic [7:0]               ahi_q;
  logic [15:0]              addr_q;
  logic                     rw_q;
  logic                     special_q;
  logic [2:0]               cs_meta_q;
  logic [2:0]               cs_sync_q;
  logic                     sda_s;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     start;
  logic                     stop;
  logic [7:0]               rx_byte;
  logic [7:0]               tx_byte;
  logic                     rx_done;
  logic                     rx_ack;
  logic                     dev_match;
  logic                     data_ok;
  logic                     load_ev;
  logic                     tx_load;

  sre_line_sync u_sync (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_sda      (sda_s),
    .o_scl_rise (scl_rise),
    .o_scl_fall (scl_fall),
    .o_start    (start),
    .o_stop     (stop)
  );

  // Straps are pins too, so they pass two flip-flops before use.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cs_meta_q <= '0;
      cs_sync_q <= '0;
    end else begin
      cs_meta_q <= {i_chip_select_bit2, i_chip_select_bit1, i_chip_select_bit0};
      cs_sync_q <= cs_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoding.

  function automatic logic [15:0] sre_next_addr(input sre_pkg::sre_area_e area, input logic [15:0] a);
    logic [15:0] n;
    n = a + 16'h0001;
    case (area)
      sre_pkg::AREA_IDENT: begin
        n = {{(sre_pkg::ADDR_W - sre_pkg::IDENT_IDX_W){1'b0}}, n[sre_pkg::IDENT_IDX_W-1:0]};
      end
      sre_pkg::AREA_SERIAL: begin
        n = {{(sre_pkg::ADDR_W - sre_pkg::SERIAL_IDX_W){1'b0}}, n[sre_pkg::SERIAL_IDX_W-1:0]};
      end
      default: begin
      end
    endcase
    return n;
  endfunction : sre_next_addr

  assign rx_byte = {shift_q[6:0], sda_s};
  assign rx_done = (st_q == ST_RX) && scl_rise && (bit_cnt_q == sre_pkg::BIT_LAST) && !start && !stop;

  assign dev_match = ((rx_byte[sre_pkg::TYPE_MSB:sre_pkg::TYPE_LSB] == sre_pkg::TYPE_MAIN) ||
                      (rx_byte[sre_pkg::TYPE_MSB:sre_pkg::TYPE_LSB] == sre_pkg::TYPE_SPECIAL)) &&
                     (rx_byte[sre_pkg::CS_MSB:sre_pkg::CS_LSB] == cs_sync_q) &&
                     !i_prog_busy;

  always_comb begin
    wr_area_d = sre_pkg::AREA_MAIN;
    if (special_q) begin
      case (ahi_q[sre_pkg::REGION_MSB:sre_pkg::REGION_LSB])
        sre_pkg::REGION_IDENT:  wr_area_d = sre_pkg::AREA_IDENT;
        sre_pkg::REGION_SERIAL: wr_area_d = sre_pkg::AREA_SERIAL;
        sre_pkg::REGION_LOCK:   wr_area_d = sre_pkg::AREA_LOCK;
        default:                wr_area_d = sre_pkg::AREA_NONE;
      endcase
    end
  end

  // Written data is never stored here; the answer alone is what matters.
  always_comb begin
    case (wr_area_q)
      sre_pkg::AREA_MAIN:  data_ok = 1'b1;
      sre_pkg::AREA_IDENT: data_ok = !i_ident_locked;
      sre_pkg::AREA_LOCK:  data_ok = !i_ident_locked;
      default:             data_ok = 1'b0;
    endcase
  end

  always_comb begin
    case (ph_q)
      sre_pkg::PH_DEV:  rx_ack = dev_match;
      sre_pkg::PH_DATA: rx_ack = data_ok;
      default:          rx_ack = 1'b1;
    endcase
  end

  assign tx_byte = (area_q == sre_pkg::AREA_SERIAL) ?
                   FACTORY_SERIAL[sre_pkg::SERIAL_W - 1 - 8 * addr_q[sre_pkg::SERIAL_IDX_W-1:0] -: 8] :
                   i_rd_data;

  assign load_ev = rx_done && (ph_q == sre_pkg::PH_ADDR_LO);
  assign tx_load = scl_fall && !start && !stop &&
                   (((st_q == ST_RX_ACK) && (ph_q == sre_pkg::PH_DEV) && rw_q) || (st_q == ST_TX_MORE));

  //////////////////////////////////////////////////////////////////////////////
  // Protocol sequencer and data line drive.

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_q      <= ST_IDLE;
      ph_q      <= sre_pkg::PH_DEV;
      bit_cnt_q <= '0;
      shift_q   <= '0;
      ahi_q     <= '0;
      rw_q      <= 1'b0;
      special_q <= 1'b0;
      wr_area_q <= sre_pkg::AREA_NONE;
      o_sda_oe  <= 1'b0;
    end else if (start) begin
      // A start mid-command abandons whatever was pending.
      st_q      <= ST_RX;
      ph_q      <= sre_pkg::PH_DEV;
      bit_cnt_q <= '0;
      wr_area_q <= sre_pkg::AREA_NONE;
      o_sda_oe  <= 1'b0;
    end else if (stop) begin
      st_q      <= ST_IDLE;
      wr_area_q <= sre_pkg::AREA_NONE;
      o_sda_oe  <= 1'b0;
    end else begin
      case (st_q)
        ST_RX: begin
          if (scl_rise) begin
            shift_q   <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == sre_pkg::BIT_LAST) begin
              st_q <= rx_ack ? ST_RX_WAIT : ST_IDLE;
              case (ph_q)
                sre_pkg::PH_DEV: begin
                  rw_q      <= rx_byte[sre_pkg::RW_BIT];
                  special_q <= rx_byte[sre_pkg::TYPE_MSB:sre_pkg::TYPE_LSB] == sre_pkg::TYPE_SPECIAL;
                end
                sre_pkg::PH_ADDR_HI: ahi_q <= rx_byte;
                sre_pkg::PH_ADDR_LO: wr_area_q <= wr_area_d;
                default: begin
                end
              endcase
            end
          end
        end
        ST_RX_WAIT: begin
          if (scl_fall) begin
            o_sda_oe <= 1'b1;
            st_q     <= ST_RX_ACK;
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= '0;
            if (tx_load) begin
              shift_q  <= tx_byte;
              o_sda_oe <= ~tx_byte[7];
              st_q     <= ST_TX;
            end else begin
              o_sda_oe <= 1'b0;
              st_q     <= ST_RX;
              ph_q     <= (ph_q == sre_pkg::PH_DEV)     ? sre_pkg::PH_ADDR_HI :
                          (ph_q == sre_pkg::PH_ADDR_HI) ? sre_pkg::PH_ADDR_LO : sre_pkg::PH_DATA;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == sre_pkg::BIT_LAST) begin
              o_sda_oe <= 1'b0;
              st_q     <= ST_TX_ACK;
            end else begin
              shift_q   <= {shift_q[6:0], 1'b0};
              o_sda_oe  <= ~shift_q[6];
              bit_cnt_q <= bit_cnt_q + 3'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            st_q <= sda_s ? ST_IDLE : ST_TX_MORE;
          end
        end
        ST_TX_MORE: begin
          if (scl_fall) begin
            shift_q   <= tx_byte;
            o_sda_oe  <= ~tx_byte[7];
            bit_cnt_q <= '0;
            st_q      <= ST_TX;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared address counter.

  // The counter survives start and stop, so a current-address read resumes here.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      addr_q <= '0;
      area_q <= sre_pkg::AREA_MAIN;
    end else if (load_ev) begin
      case (wr_area_d)
        sre_pkg::AREA_MAIN: begin
          addr_q <= {ahi_q, rx_byte};
          area_q <= sre_pkg::AREA_MAIN;
        end
        sre_pkg::AREA_IDENT: begin
          addr_q <= {{(sre_pkg::ADDR_W - sre_pkg::IDENT_IDX_W){1'b0}}, rx_byte[sre_pkg::IDENT_IDX_W-1:0]};
          area_q <= sre_pkg::AREA_IDENT;
        end
        sre_pkg::AREA_SERIAL: begin
          addr_q <= {{(sre_pkg::ADDR_W - sre_pkg::SERIAL_IDX_W){1'b0}}, rx_byte[sre_pkg::SERIAL_IDX_W-1:0]};
          area_q <= sre_pkg::AREA_SERIAL;
        end
        default: begin
        end
      endcase
    end else if (tx_load) begin
      addr_q <= sre_next_addr(area_q, addr_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Memory read port; the byte is fetched a full byte time before it is needed.

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_addr  <= '0;
      o_rd_ident <= 1'b0;
      o_sda_out  <= 1'b0;
    end else begin
      o_rd_addr  <= addr_q;
      o_rd_ident <= area_q == sre_pkg::AREA_IDENT;
      o_sda_out  <= 1'b0;
    end
  end
endmodule : sre_read_engine
`default_nettype wire

// ### dv/sre_read_engine_asserts.sv
// Purpose: Port checks on the serial data drive of the read engine.
// Assumes: The serial clock is far slower than i_mclk.
// Notes:   Bound to every instance of the engine.
`timescale 1ns/1ps
`default_nettype none
module sre_read_engine_asserts (
  input wire logic i_mclk,      // System clock.
  input wire logic i_rst,       // Reset, active high.
  input wire logic i_scl,       // Serial clock pin.
  input wire logic i_sda,       // Resolved data line.
  input wire logic o_sda_out,   // Data drive value.
  input wire logic o_sda_oe,    // Data drive enable.
  input wire logic i_prog_busy  // Programming running.
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Nine all-zero bits in a row is the longest legal pull, so a stuck enable shows here.
  logic [7:0] oe_len_q;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) oe_len_q <= 8'h00;
    else if (!o_sda_oe) oe_len_q <= 8'h00;
    else if (oe_len_q != 8'hFF) oe_len_q <= oe_len_q + 8'h01;
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_out_zero; o_sda_out == 1'b0; endproperty
  a_out_zero: assert property (p_out_zero)
    else $error("data drive value not zero");
  property p_oe_edge; $changed(o_sda_oe) |-> !i_scl; endproperty
  a_oe_edge: assert property (p_oe_edge)
    else $error("data drive changed while clock high");
  property p_oe_after_fall; $rose(o_sda_oe) |-> !$past(i_scl, 2); endproperty
  a_oe_after_fall: assert property (p_oe_after_fall)
    else $error("data drive rose too soon after clock fall");
  property p_oe_width; $rose(o_sda_oe) |-> o_sda_oe [*8]; endproperty
  a_oe_width: assert property (p_oe_width)
    else $error("data drive pulse too short");
  property p_oe_max; oe_len_q <= 8'hC8; endproperty
  a_oe_max: assert property (p_oe_max)
    else $error("data drive held too long");
  property p_busy_quiet; i_prog_busy |-> !$rose(o_sda_oe); endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("device answered while busy");
  property p_start_rel; i_scl && $fell(i_sda) |-> ##[1:6] !o_sda_oe; endproperty
  a_start_rel: assert property (p_start_rel)
    else $error("data not released after start");
  property p_stop_rel; i_scl && $rose(i_sda) |-> ##[1:6] !o_sda_oe; endproperty
  a_stop_rel: assert property (p_stop_rel)
    else $error("data not released after stop");
endmodule : sre_read_engine_asserts
bind sre_read_engine sre_read_engine_asserts u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_prog_busy(i_prog_busy));
`default_nettype wire

// ### dv/sre_i2c_master.sv
// Purpose: Behavioural two-wire bus master facing the read engine.
// Assumes: 80 ns serial clock period, pulled-up data line.
// Notes:   Clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module sre_i2c_master (
  output logic      o_scl,     // Serial clock, idle high.
  output logic      o_sda_low, // High pulls the data line low.
  input  wire logic i_sda      // Resolved data line.
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic pin_bit(input logic b, output logic r);
    o_sda_low = ~b;
    #20 o_scl = 1'b1;
    #20 r = i_sda;
    #20 o_scl = 1'b0;
    #20;
  endtask : pin_bit
  // Releasing data first lets a start follow an acknowledge or a read bit.
  task automatic start();
    o_sda_low = 1'b0;
    #20 o_scl = 1'b1;
    #40 o_sda_low = 1'b1;
    #40 o_scl = 1'b0;
    #20;
  endtask : start
  task automatic stop();
    o_sda_low = 1'b1;
    #20 o_scl = 1'b1;
    #40 o_sda_low = 1'b0;
    #40;
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) pin_bit(d[i], r);
    pin_bit(1'b1, r);
    ok = !r;
  endtask : wbyte
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) pin_bit(1'b1, d[i]);
    pin_bit(!ack, r);
  endtask : rbyte
endmodule : sre_i2c_master
`default_nettype wire

// ### dv/sre_read_engine_tb.sv
// Purpose: Self-checking bench of the read engine against a byte model.
// Assumes: Memory answers combinationally from the read address.
// Notes:   Model keeps its own address counter and area.
`timescale 1ns/1ps
`default_nettype none
module sre_read_engine_tb;
  localparam logic [127:0] SER = 128'h5A17C39E04B2D8F16E2A93C75B08F4D1; // Arbitrary value.
  logic        i_mclk, i_rst, scl, m_low, sda, oe, sda_out, busy, locked, rd_ident;
  logic [2:0]  cs;
  logic [15:0] rd_addr;
  logic [7:0]  rd_data;
  int          miscompares, n_compared, mcnt, marea;
  function automatic logic [7:0] mem_byte(input int area, input int a);
    logic [15:0] w;
    w = a[15:0];
    if (area == 2) return SER[127 - 8 * (a % 16) -: 8];
    if (area == 1) return {1'b0, w[6:0]} ^ 8'hA5;
    return w[7:0] ^ w[15:8] ^ 8'h3C;
  endfunction : mem_byte
  assign sda = ~(m_low | oe);
  assign rd_data = mem_byte(rd_ident ? 1 : 0, int'(rd_addr));
  sre_i2c_master u_master (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
  sre_read_engine #(.FACTORY_SERIAL(SER)) uut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(oe),
    .i_chip_select_bit2(cs[2]), .i_chip_select_bit1(cs[1]), .i_chip_select_bit0(cs[0]),
    .i_prog_busy(busy), .i_ident_locked(locked), .o_rd_addr(rd_addr), .o_rd_ident(rd_ident),
    .i_rd_data(rd_data));
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic send(input logic [7:0] d, input logic exp_ack, input string what);
    logic a;
    u_master.wbyte(d, a);
    chk(what, {7'h0, exp_ack}, {7'h0, a});
  endtask : send
  task automatic wr_head(input logic [3:0] ty, input logic [15:0] a);
    u_master.start();
    send({ty, cs, 1'b0}, 1'b1, "dev ack");
    send(a[15:8], 1'b1, "hi ack");
    send(a[7:0], 1'b1, "lo ack");
  endtask : wr_head
  task automatic dummy(input logic [3:0] ty, input logic [15:0] a);
    wr_head(ty, a);
    marea = (ty == sre_pkg::TYPE_MAIN) ? 0 : ((a[11:9] == sre_pkg::REGION_IDENT) ? 1 : 2);
    mcnt = (marea == 0) ? int'(a) : ((marea == 1) ? int'(a[6:0]) : int'(a[3:0]));
  endtask : dummy
  task automatic rd(input logic [3:0] ty, input int n);
    logic [7:0] d;
    u_master.start();
    send({ty, cs, 1'b1}, 1'b1, "read dev ack");
    for (int i = 0; i < n; i++) begin
      u_master.rbyte(i < n - 1, d);
      chk("data", mem_byte(marea, mcnt), d);
      mcnt = (mcnt + 1) % ((marea == 0) ? 65536 : ((marea == 1) ? 128 : 16));
    end
    u_master.stop();
  endtask : rd
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h69ebabb8));
    {miscompares, n_compared, mcnt, marea} = '0;
    cs = 3'($urandom);
    {busy, locked} = 2'h0;
    i_rst = 1'b1;
    repeat (4) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    repeat (8) @(posedge i_mclk);
    for (int k = 0; k < 3; k++) begin
      dummy(sre_pkg::TYPE_MAIN, 16'($urandom));
      rd(sre_pkg::TYPE_MAIN, 1 + 2 * k);
    end
    rd(sre_pkg::TYPE_MAIN, 2);
    dummy(sre_pkg::TYPE_MAIN, 16'hFFFE);
    rd(sre_pkg::TYPE_MAIN, 4);
    $display("test main array reads done");
    dummy(sre_pkg::TYPE_SPECIAL, {4'($urandom), 3'h0, 2'($urandom), 7'h7E});
    rd(sre_pkg::TYPE_SPECIAL, 3);
    rd(sre_pkg::TYPE_SPECIAL, 2);
    dummy(sre_pkg::TYPE_SPECIAL, {4'($urandom), 3'h1, 5'($urandom), 4'h0});
    rd(sre_pkg::TYPE_SPECIAL, 17);
    $display("test special area reads done");
    for (int l = 0; l < 2; l++) begin
      @(posedge i_mclk);
      #1 locked = l[0];
      wr_head(sre_pkg::TYPE_SPECIAL, {4'($urandom), 3'h2, 9'($urandom)});
      send(8'($urandom), !locked, "lock state ack");
      u_master.start();
      u_master.stop();
    end
    // Region 001 is the serial block; region 011 is decoded as no area and must refuse too.
    for (int r = 1; r < 4; r += 2) begin
      wr_head(sre_pkg::TYPE_SPECIAL, {4'($urandom), 3'(r), 9'($urandom)});
      send(8'($urandom), 1'b0, "serial write ack");
      u_master.stop();
    end
    $display("test lock query and serial write done");
    @(posedge i_mclk);
    #1 busy = 1'b1;
    u_master.start();
    send({sre_pkg::TYPE_MAIN, cs, 1'b1}, 1'b0, "busy dev ack");
    u_master.stop();
    @(posedge i_mclk);
    #1 busy = 1'b0;
    u_master.start();
    send({sre_pkg::TYPE_MAIN, cs ^ 3'h5, 1'b1}, 1'b0, "cs mismatch ack");
    u_master.start();
    send({4'h5, cs, 1'b1}, 1'b0, "bad type ack");
    u_master.stop();
    dummy(sre_pkg::TYPE_MAIN, 16'($urandom));
    rd(sre_pkg::TYPE_MAIN, 2);
    $display("test refusals done");
    report_and_stop();
  end
endmodule : sre_read_engine_tb
`default_nettype wire
